// [design/obl_loader.sv]
// Option byte and trim loader that holds the core in reset until done.
`timescale 1ns/1ps
`default_nettype none
`include "obl_params.svh"
module obl_loader #(
   parameter int TRIM_COUNT = `OBL_TRIM_COUNT
) (
   // Clock and resets
   input  wire logic               clk,
   input  wire logic               rst,
   input  wire logic               stopRecovery,
   // Flash read port, data valid the cycle after the request
   output logic                    flashRd,
   output logic                    flashInfo,
   output logic [15:0]             flashAddr,
   input  wire logic [7:0]         flashData,
   // Register port from the core
   input  wire obl_pkg::obl_reg_req_s regReq,
   output logic [7:0]              regRdata,
   output logic                    regHit,
   // Core reset hold
   output logic                    coreResetHold,
   // Decoded option settings
   output obl_pkg::obl_opt0_s      opt0,
   output logic [7:0]              opt1,
   output logic                    watchdogResponseSelect,
   output logic                    watchdogAlwaysOnN,
   output logic [1:0]              oscillatorModeField,
   output logic                    brownoutAlwaysOn,
   output logic                    codeReadGuardN,
   output logic                    programRamMapSelect,
   output logic                    flashWriteGuardN,
   output logic [8*TRIM_COUNT-1:0] trimFlat
);
   import obl_pkg::*;

   obl_state_e state_r;
   obl_state_e state_nxt;
   logic [4:0] cnt_r;
   logic [4:0] cnt_nxt;
   logic       pend_r;
   logic       pend_nxt;
   logic [7:0] opt0_r;
   logic [7:0] opt0_nxt;
   logic [7:0] opt1_r;
   logic [7:0] opt1_nxt;
   logic       hold_r;
   logic       hold_nxt;
   logic       fillWe;
   logic       reload;
   obl_reg_req_s gatedReq;

   // Stop recovery reloads like a system reset, except that only system reset clears the trim index.
   assign reload = rst | stopRecovery;

   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      pend_nxt  = 1'b0;
      opt0_nxt  = opt0_r;
      opt1_nxt  = opt1_r;
      hold_nxt  = hold_r;
      flashRd   = 1'b0;
      flashInfo = 1'b0;
      flashAddr = 16'h0000;
      fillWe    = 1'b0;
      case (state_r)
         OBL_IDLE: begin
            hold_nxt  = 1'b1;
            state_nxt = OBL_OPT0;
         end
         OBL_OPT0: begin
            flashRd   = ~pend_r;
            flashAddr = `OBL_OPT0_ADDR;
            pend_nxt  = ~pend_r;
            if (pend_r) begin
               opt0_nxt  = flashData;
               state_nxt = OBL_OPT1;
            end
         end
         OBL_OPT1: begin
            flashRd   = ~pend_r;
            flashAddr = `OBL_OPT1_ADDR;
            pend_nxt  = ~pend_r;
            if (pend_r) begin
               opt1_nxt  = flashData;
               cnt_nxt   = 5'd0;
               state_nxt = OBL_TRIM;
            end
         end
         OBL_TRIM: begin
            // Trims come from the information page, untouched by erase.
            flashRd   = ~pend_r;
            flashInfo = 1'b1;
            flashAddr = {8'h00, `OBL_TRIM_BASE + {3'b000, cnt_r}};
            pend_nxt  = ~pend_r;
            if (pend_r) begin
               fillWe  = 1'b1;
               cnt_nxt = cnt_r + 5'd1;
               if (cnt_r == 5'(TRIM_COUNT - 1)) begin
                  state_nxt = OBL_DONE;
               end
            end
         end
         OBL_DONE: begin
            hold_nxt = 1'b0;
         end
         default: begin
            state_nxt = OBL_IDLE;
         end
      endcase
   end

   // Latches change only during a load, never on a later flash update.
   always_ff @(posedge clk) begin
      if (reload) begin
         state_r <= OBL_IDLE;
         cnt_r   <= 5'd0;
         pend_r  <= 1'b0;
         hold_r  <= 1'b1;
         opt0_r  <= `OBL_ERASED_BYTE;
         opt1_r  <= `OBL_ERASED_BYTE;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         pend_r  <= pend_nxt;
         hold_r  <= hold_nxt;
         opt0_r  <= opt0_nxt;
         opt1_r  <= opt1_nxt;
      end
   end

   // The core cannot touch registers while held, and the option latches
   // have no address at all. The reset level is included so that a request
   // in the first reset cycle is refused before the hold flop catches up.
   always_comb begin
      gatedReq    = regReq;
      gatedReq.rd = regReq.rd & ~(hold_r | reload);
      gatedReq.wr = regReq.wr & ~(hold_r | reload);
   end

   obl_trim_regs #(
      .TRIM_COUNT(TRIM_COUNT)
   ) uTrim (
      .clk      (clk),
      .rst      (rst),
      .req      (gatedReq),
      .rdata    (regRdata),
      .hit      (regHit),
      .fillWe   (fillWe),
      .fillIdx  (cnt_r),
      .fillData (flashData),
      .trimFlat (trimFlat)
   );

   assign coreResetHold = hold_r | reload;
   assign opt0 = opt0_r;
   assign opt1 = opt1_r;
   // Interrupt acceptance is left to the core's global enable.
   assign watchdogResponseSelect = opt0_r[`OBL_BIT_WD_RESP];
   assign watchdogAlwaysOnN      = opt0_r[`OBL_BIT_WD_ON_N];
   assign oscillatorModeField    = opt0_r[`OBL_OSC_HI:`OBL_OSC_LO];
   assign brownoutAlwaysOn       = opt0_r[`OBL_BIT_BO_ON];
   assign codeReadGuardN         = opt0_r[`OBL_BIT_RD_GRD_N];
   assign programRamMapSelect    = opt0_r[`OBL_BIT_PRAM_SEL];
   assign flashWriteGuardN       = opt0_r[`OBL_BIT_WR_GRD_N];
endmodule : obl_loader
`default_nettype wire

// [design/obl_params.svh]
// Constants for the option bit loader.
// Behaviour
// - Reprogrammed option bytes take effect only after the next reset.
// - Every reset, system or stop recovery, reloads option bytes into latches.
// - Loading completes before the core is released from reset.
// - Option latches are not reachable by software reads or writes.
// - User option bytes come from program addresses zero and one.
// - Page zero erase clears option bytes; erased values apply next reset.
// - Trim bytes live in the information page; program erase spares them.
// - Trim data writes change only the volatile working copy.
// - Trim index write then data write updates that working trim byte.
// - Trim index write then data read returns that working trim byte.
// - Trim indices reach only information offsets 20h to 3Fh.
// - Byte zero bit 7 picks watchdog response; 1 means reset.
// - Byte zero bit 6 low forces watchdog on from power-up.
// - Bits 5:4 select oscillator mode; 01 reserved, 11 default.
// - Bit 3 high keeps brown-out protection always on.
// - Bit 2 low blocks external code access and limits debugging.
// - Bit 1 selects program RAM mapping; high maps at E000h.
// - Bit 0 low blocks user programming and erase of flash.
`ifndef OBL_PARAMS_SVH
`define OBL_PARAMS_SVH
`define OBL_OPT0_ADDR     16'h0000
`define OBL_OPT1_ADDR     16'h0001
`define OBL_TRIM_BASE     8'h20
`define OBL_TRIM_COUNT    32
`define OBL_TRIM_IDX_MASK 8'h1F
`define OBL_ERASED_BYTE   8'hFF
`define OBL_TRIM_ADR_REG  12'hFF6
`define OBL_TRIM_DAT_REG  12'hFF7
`define OBL_BIT_WD_RESP   7
`define OBL_BIT_WD_ON_N   6
`define OBL_OSC_HI        5
`define OBL_OSC_LO        4
`define OBL_BIT_BO_ON     3
`define OBL_BIT_RD_GRD_N  2
`define OBL_BIT_PRAM_SEL  1
`define OBL_BIT_WR_GRD_N  0
`endif

// [design/obl_pkg.sv]
// Types for the option bit loader.
package obl_pkg;
   typedef enum logic [4:0] {
      OBL_IDLE = 5'b00001,
      OBL_OPT0 = 5'b00010,
      OBL_OPT1 = 5'b00100,
      OBL_TRIM = 5'b01000,
      OBL_DONE = 5'b10000
   } obl_state_e;

   typedef struct packed {
      logic       watchdogResponseSelect;
      logic       watchdogAlwaysOnN;
      logic [1:0] oscillatorModeField;
      logic       brownoutAlwaysOn;
      logic       codeReadGuardN;
      logic       programRamMapSelect;
      logic       flashWriteGuardN;
   } obl_opt0_s;

   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [11:0] addr;
      logic [7:0]  wdata;
   } obl_reg_req_s;
endpackage : obl_pkg

// [design/obl_trim_regs.sv]
// Trim index and trim working copy register access.
`timescale 1ns/1ps
`default_nettype none
`include "obl_params.svh"
module obl_trim_regs #(
   parameter int TRIM_COUNT = `OBL_TRIM_COUNT
) (
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               rst,
   // Register port
   input  wire obl_pkg::obl_reg_req_s req,
   output logic [7:0]              rdata,
   output logic                    hit,
   // Loader fill port
   input  wire logic               fillWe,
   input  wire logic [4:0]         fillIdx,
   input  wire logic [7:0]         fillData,
   // Working trim copy
   output logic [8*TRIM_COUNT-1:0] trimFlat
);
   import obl_pkg::*;

   logic [7:0] trimMem_r [TRIM_COUNT];
   logic [7:0] trimMem_nxt [TRIM_COUNT];
   logic [7:0] trimIndex_r;
   logic [7:0] trimIndex_nxt;
   logic [7:0] rdata_nxt;
   logic       idxSel;
   logic       datSel;

   // Only the low five bits select a byte, so no other page location leaks.
   function automatic logic [4:0] trimSlot(input logic [7:0] idx);
      trimSlot = 5'(idx & `OBL_TRIM_IDX_MASK);
   endfunction : trimSlot

   always_comb begin
      idxSel        = req.addr == `OBL_TRIM_ADR_REG;
      datSel        = req.addr == `OBL_TRIM_DAT_REG;
      hit           = (req.rd | req.wr) & (idxSel | datSel);
      trimIndex_nxt = trimIndex_r;
      trimMem_nxt   = trimMem_r;
      rdata_nxt     = 8'h00;
      if (req.wr && idxSel) begin
         trimIndex_nxt = req.wdata;
      end
      if (fillWe) begin
         trimMem_nxt[fillIdx] = fillData;
      end else if (req.wr && datSel) begin
         trimMem_nxt[trimSlot(trimIndex_r)] = req.wdata;
      end
      if (req.rd && datSel) begin
         rdata_nxt = trimMem_r[trimSlot(trimIndex_r)];
      end else if (req.rd && idxSel) begin
         rdata_nxt = trimIndex_r;
      end
   end

   // Working copy is not cleared by reset: it is refilled by the loader.
   always_ff @(posedge clk) begin
      trimMem_r <= trimMem_nxt;
      rdata     <= rdata_nxt;
      if (rst) begin
         trimIndex_r <= 8'h00;
      end else begin
         trimIndex_r <= trimIndex_nxt;
      end
   end

   always_comb begin
      for (int i = 0; i < TRIM_COUNT; i++) begin
         trimFlat[8*i +: 8] = trimMem_r[i];
      end
   end
endmodule : obl_trim_regs
`default_nettype wire

// [sim/obl_loader_props.sv]
// Concurrent checks on the option bit loader ports.
`timescale 1ns/1ps
`default_nettype none
module obl_loader_props (
   // Clock and resets
   input wire logic                 clk,
   input wire logic                 rst,
   input wire logic                 stopRecovery,
   // Flash port
   input wire logic                 flashRd,
   input wire logic                 flashInfo,
   input wire logic [15:0]          flashAddr,
   input wire logic [7:0]           flashData,
   // Register port
   input wire obl_pkg::obl_reg_req_s regReq,
   input wire logic                 regHit,
   // Core side
   input wire logic                 coreResetHold,
   input wire obl_pkg::obl_opt0_s   opt0,
   input wire logic                 watchdogResponseSelect,
   input wire logic                 watchdogAlwaysOnN,
   input wire logic [1:0]           oscillatorModeField,
   input wire logic                 brownoutAlwaysOn,
   input wire logic                 codeReadGuardN,
   input wire logic                 programRamMapSelect,
   input wire logic                 flashWriteGuardN
);
   import obl_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   property p_holdAfterRst;
      $fell(rst) |-> coreResetHold;
   endproperty
   a_holdAfterRst: assert property (p_holdAfterRst)
      else $error("core released before load");
   property p_rdInHold;
      flashRd |-> coreResetHold;
   endproperty
   a_rdInHold: assert property (p_rdInHold)
      else $error("flash read outside reset hold");
   property p_optStable;
      !coreResetHold && !stopRecovery |=> $stable(opt0);
   endproperty
   a_optStable: assert property (p_optStable)
      else $error("option byte changed outside reset");
   property p_decode;
      {watchdogResponseSelect, watchdogAlwaysOnN, oscillatorModeField,
       brownoutAlwaysOn, codeReadGuardN, programRamMapSelect,
       flashWriteGuardN} == opt0;
   endproperty
   a_decode: assert property (p_decode)
      else $error("decoded option bits differ from byte zero");
   property p_userAddr;
      flashRd && !flashInfo |-> flashAddr inside {16'h0000, 16'h0001};
   endproperty
   a_userAddr: assert property (p_userAddr)
      else $error("user option read outside bytes zero and one");
   property p_trimAddr;
      flashRd && flashInfo |-> flashAddr inside {[16'h0020:16'h003F]};
   endproperty
   a_trimAddr: assert property (p_trimAddr)
      else $error("trim read outside info offsets 20h to 3Fh");
   property p_rdPulse;
      flashRd |=> !flashRd;
   endproperty
   a_rdPulse: assert property (p_rdPulse)
      else $error("flash read held longer than one cycle");
   property p_capture;
      (flashRd && !flashInfo && flashAddr == 16'h0000) ##1 1'b1
         |=> opt0 == $past(flashData);
   endproperty
   a_capture: assert property (p_capture)
      else $error("byte zero not latched from flash");
   property p_unmapped;
      !(regReq.addr inside {12'hFF6, 12'hFF7}) |-> !regHit;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("register hit on an unmapped address");
   property p_holdNoHit;
      coreResetHold |-> !regHit;
   endproperty
   a_holdNoHit: assert property (p_holdNoHit)
      else $error("register hit while core reset is held");
endmodule : obl_loader_props
bind obl_loader obl_loader_props u_props (.clk(clk), .rst(rst),
   .stopRecovery(stopRecovery), .flashRd(flashRd), .flashInfo(flashInfo),
   .flashAddr(flashAddr), .flashData(flashData), .regReq(regReq),
   .regHit(regHit), .coreResetHold(coreResetHold), .opt0(opt0),
   .watchdogResponseSelect(watchdogResponseSelect),
   .watchdogAlwaysOnN(watchdogAlwaysOnN),
   .oscillatorModeField(oscillatorModeField),
   .brownoutAlwaysOn(brownoutAlwaysOn), .codeReadGuardN(codeReadGuardN),
   .programRamMapSelect(programRamMapSelect),
   .flashWriteGuardN(flashWriteGuardN));
`default_nettype wire

// [sim/obl_flash_model.sv]
// Behavioural flash array answering the loader one cycle after a read.
`timescale 1ns/1ps
`default_nettype none
module obl_flash_model (
   // Clock
   input wire logic         clk,
   // Read port
   input wire logic         flashRd,
   input wire logic         flashInfo,
   input wire logic [15:0]  flashAddr,
   output logic [7:0]       flashData = 8'h00,
   // Programmed user bytes
   input wire logic [7:0]   optByte0,
   input wire logic [7:0]   optByte1
);
   // Outside the valid cycle the data is inverted so stale bytes show up.
   always @(posedge clk) begin
      if (!flashRd) flashData <= ~flashData;
      else if (flashInfo) flashData <= flashAddr[7:0] ^ 8'hC3;
      else if (flashAddr == 16'h0000) flashData <= optByte0;
      else if (flashAddr == 16'h0001) flashData <= optByte1;
      else flashData <= 8'hEE;
   end
endmodule : obl_flash_model
`default_nettype wire

// [sim/option_bit_loader_tb.sv]
// Self-checking bench for the option bit loader.
`timescale 1ns/1ps
`default_nettype none
module option_bit_loader_tb;
   import obl_pkg::*;
   logic clk = 1'b0, rst = 1'b1, stopRecovery = 1'b0;
   logic [7:0] optByte0 = 8'hFF, optByte1 = 8'hFF, prev, b, q, hw, t;
   obl_reg_req_s regReq = '0;
   logic flashRd, flashInfo, regHit, coreResetHold, h;
   logic [15:0] flashAddr;
   logic [7:0] flashData, regRdata, opt1;
   obl_opt0_s opt0;
   logic wdR, wdA, boA, crG, prM, fwG;
   logic [1:0] osc;
   logic [255:0] trimFlat;
   int n_fail = 0, n_compared = 0;
   initial forever #25 clk = ~clk;
   obl_loader uut (.clk(clk), .rst(rst), .stopRecovery(stopRecovery),
      .flashRd(flashRd), .flashInfo(flashInfo), .flashAddr(flashAddr),
      .flashData(flashData), .regReq(regReq), .regRdata(regRdata),
      .regHit(regHit), .coreResetHold(coreResetHold), .opt0(opt0),
      .opt1(opt1), .watchdogResponseSelect(wdR), .watchdogAlwaysOnN(wdA),
      .oscillatorModeField(osc), .brownoutAlwaysOn(boA),
      .codeReadGuardN(crG), .programRamMapSelect(prM),
      .flashWriteGuardN(fwG), .trimFlat(trimFlat));
   obl_flash_model u_flash (.clk(clk), .flashRd(flashRd),
      .flashInfo(flashInfo), .flashAddr(flashAddr), .flashData(flashData),
      .optByte0(optByte0), .optByte1(optByte1));
   task automatic complete_run;
      $display("compared %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : complete_run
   task automatic chk(input string nm, input logic [7:0] e, g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wait_load;
      for (int i = 0; i < 200 && coreResetHold !== 1'b0; i++) begin
         @(posedge clk);
         #1;
      end
      chk("hold", 8'h00, {7'h00, coreResetHold});
      if (coreResetHold !== 1'b0) complete_run;
   endtask : wait_load
   // Reset and stop recovery both reload, so either one is used here.
   task automatic reload(input logic stop);
      @(posedge clk);
      if (stop) stopRecovery <= 1'b1;
      else rst <= 1'b1;
      repeat (4) @(posedge clk);
      stopRecovery <= 1'b0;
      rst <= 1'b0;
      wait_load;
   endtask : reload
   task automatic reg_op(input logic w, input logic [11:0] a,
                         input logic [7:0] d);
      @(posedge clk);
      regReq <= '{rd: !w, wr: w, addr: a, wdata: d};
      #1 h = regHit;
      @(posedge clk);
      regReq <= '0;
      #1 q = regRdata;
   endtask : reg_op
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      wait_load;
      chk("opt0", 8'hFF, opt0);
      chk("opt1", 8'hFF, opt1);
      $display("erased test done");
      prev = 8'hFF;
      for (int k = 0; k < 4; k++) begin
         b = {k[0], ~k[0], k[1:0], k[1], ~k[1], ~k[0], k[0]};
         optByte0 <= b;
         optByte1 <= ~b;
         repeat (3) @(posedge clk);
         chk("opt0 held", prev, opt0);
         reload(k[0]);
         chk("opt0", b, opt0);
         chk("opt1", ~b, opt1);
         chk("osc", {6'h00, k[1:0]}, {6'h00, osc});
         chk("bits", b, {wdR, wdA, osc, boA, crG, prM, fwG});
         chk("wd response", b & 8'h80, {wdR, 7'h00});
         chk("ram map", b & 8'h03, {6'h00, prM, fwG});
         prev = b;
      end
      $display("option test done");
      for (int i = 0; i < 32; i++) begin
         t = 8'(8'h20 + i);
         chk("trim", t ^ 8'hC3, trimFlat[8*i+:8]);
      end
      reg_op(1'b1, 12'hFF6, 8'h1F);
      reg_op(1'b1, 12'hFF7, 8'h5A);
      hw = {7'h00, h};
      chk("trim byte", 8'h5A, trimFlat[255:248]);
      reg_op(1'b0, 12'hFF7, 8'h00);
      chk("trim read", 8'h5A, q);
      chk("hit", 8'h01, hw);
      reg_op(1'b0, 12'hFF6, 8'h00);
      chk("index", 8'h1F, q);
      reg_op(1'b0, 12'hFF5, 8'h00);
      chk("unmapped", 8'h00, {h, q[6:0]});
      // A write issued while the loader holds the core must be refused.
      @(posedge clk);
      stopRecovery <= 1'b1;
      reg_op(1'b1, 12'hFF6, 8'h05);
      chk("held hit", 8'h00, {7'h00, h});
      @(posedge clk);
      stopRecovery <= 1'b0;
      wait_load;
      reg_op(1'b0, 12'hFF6, 8'h00);
      chk("held index", 8'h1F, q);
      reload(1'b0);
      chk("trim reload", 8'h3F ^ 8'hC3, trimFlat[255:248]);
      $display("trim test done");
      complete_run;
   end
endmodule : option_bit_loader_tb
`default_nettype wire
